/* include/moc_pkg.sv */
// Package: register map, event carriers and constants of the octet/collision statistics block
package moc_pkg;

  localparam int          CNT_W         = 32;
  localparam int          OCTET_W       = 16;
  localparam int          NUM_CNT       = 3;
  localparam int          VLAN_TAG_OCTETS = 4;

  // Counter offsets, identical in the I/O and the memory window
  localparam logic [7:0]  RX_OCTET_OFFSET  = 8'ha8;
  localparam logic [7:0]  TX_OCTET_OFFSET  = 8'hb0;
  localparam logic [7:0]  ONE_COL_OFFSET   = 8'hb4;

  localparam logic [31:0] CNT_RESET_VALUE  = 32'h0000_0000;
  localparam logic [31:0] CNT_THRESHOLD    = 32'hc000_0000;
  localparam logic [31:0] UNMAPPED_VALUE   = 32'h0000_0000;

  // Configuration space: power-management capability
  localparam logic [7:0]  CAP_ID_OFFSET    = 8'h50;
  localparam logic [7:0]  CAP_ID_POWER_MGT = 8'h01;
  localparam logic [7:0]  CFG_UNMAPPED     = 8'h00;

  // Counter indices in the per-counter mask
  localparam int          IDX_RX  = 0;
  localparam int          IDX_TX  = 1;
  localparam int          IDX_COL = 2;
  localparam logic [1:0]  IDX_NONE = 2'h3;

  typedef struct packed {
    logic               done;
    logic               good;
    logic               too_long;
    logic               fcs_err;
    logic               len_err;
    logic               align_err;
    logic               overrun;
    logic               vlan_stripped;
    logic [OCTET_W-1:0] octets;
  } moc_rx_event_type;

  typedef struct packed {
    logic               done;
    logic               good;
    logic               vlan_inserted;
    logic [3:0]         collisions;
    logic [OCTET_W-1:0] octets;
  } moc_tx_event_type;

  typedef struct packed {
    logic               rd;
    logic               wr;
    logic               mem_window;
    logic [7:0]         offset;
    logic [CNT_W-1:0]   wdata;
  } moc_reg_req_type;

  typedef struct packed {
    logic               rd;
    logic [7:0]         addr;
  } moc_cfg_req_type;

endpackage

/* design/moc_stat_counter.sv */
// Module: one wrapping statistics counter with software load and threshold detect
module moc_stat_counter #(
  parameter int               WIDTH  = 32,
  parameter int               AMT_W  = 16,
  parameter logic [WIDTH-1:0] THRESH = 32'hc000_0000,
  parameter logic [WIDTH-1:0] RESET  = 32'h0000_0000
) (
  input  wire logic             ref_clk_i,
  input  wire logic             rst_i,
  input  wire logic             count_en_i,
  input  wire logic             inc_valid_i,
  input  wire logic [AMT_W-1:0] inc_amount_i,
  input  wire logic             load_i,
  input  wire logic [WIDTH-1:0] load_value_i,
  output logic      [WIDTH-1:0] value_o,
  output logic                  thresh_hit_o
);

  logic [WIDTH:0]   wide_sum;
  logic [WIDTH-1:0] next_value;
  logic             step;

  assign step       = count_en_i && inc_valid_i && !load_i;
  assign wide_sum   = {1'b0, value_o} + {{(WIDTH + 1 - AMT_W){1'b0}}, inc_amount_i};
  // Carry dropped on purpose: all-ones rolls over to zero
  assign next_value = wide_sum[WIDTH-1:0];
  // Octet steps can jump past the exact value, so detect the crossing
  assign thresh_hit_o = step && (value_o < THRESH) && (wide_sum >= {1'b0, THRESH});

  always_ff @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      value_o <= RESET;
    end else if (load_i) begin
      value_o <= load_value_i;
    end else if (step) begin
      value_o <= next_value;
    end
  end

endmodule // moc_stat_counter

/* design/moc_stats_top.sv */
// Module: receive/transmit octet and single-collision statistics with capability ID byte
module moc_stats_top #(
  parameter int CNT_W   = moc_pkg::CNT_W,
  parameter int OCTET_W = moc_pkg::OCTET_W
) (
  input  wire logic                     ref_clk_i,
  input  wire logic                     rst_i,
  input  wire moc_pkg::moc_rx_event_type rx_event_i,
  input  wire moc_pkg::moc_tx_event_type tx_event_i,
  input  wire logic                     global_counting_enable_i,
  input  wire logic [2:0]               per_counter_mask_i,
  input  wire logic                     stats_threshold_clear_i,
  input  wire moc_pkg::moc_reg_req_type  reg_req_i,
  input  wire moc_pkg::moc_cfg_req_type  cfg_req_i,
  output logic      [CNT_W-1:0]         reg_rdata_o,
  output logic                          reg_rvalid_o,
  output logic      [7:0]               cfg_rdata_o,
  output logic                          cfg_rvalid_o,
  output logic                          stats_threshold_flag_o
);

  ////////////////////////////////////////////////////////////////////////////////
  // Decode

  // Same offset map whichever window carried the access
  function automatic logic [1:0] counter_index(input logic [7:0] offset);
    unique case (offset)
      moc_pkg::RX_OCTET_OFFSET: counter_index = 2'(moc_pkg::IDX_RX);
      moc_pkg::TX_OCTET_OFFSET: counter_index = 2'(moc_pkg::IDX_TX);
      moc_pkg::ONE_COL_OFFSET:  counter_index = 2'(moc_pkg::IDX_COL);
      default:                  counter_index = moc_pkg::IDX_NONE;
    endcase
  endfunction

  logic [1:0]         wr_index;
  logic [1:0]         rd_index;
  logic [2:0]         count_en;
  logic [2:0]         inc_valid;
  logic [2:0]         load;
  logic [2:0]         thresh_hit;
  logic [OCTET_W-1:0] inc_amount [3];
  logic [CNT_W-1:0]   cnt_value  [3];
  logic [OCTET_W-1:0] rx_amount;
  logic [OCTET_W-1:0] tx_amount;
  logic               rx_counted;
  logic               tx_counted;
  logic               one_col_counted;

  assign wr_index = counter_index(reg_req_i.offset);
  assign rd_index = counter_index(reg_req_i.offset);

  ////////////////////////////////////////////////////////////////////////////////
  // Frame qualification

  assign rx_counted = rx_event_i.done && rx_event_i.good && !rx_event_i.too_long && !rx_event_i.fcs_err
                      && !rx_event_i.len_err && !rx_event_i.align_err && !rx_event_i.overrun;
  // Stripped tags never reach the length field, so they are added back
  assign rx_amount  = rx_event_i.octets + (rx_event_i.vlan_stripped ?
                      OCTET_W'(moc_pkg::VLAN_TAG_OCTETS) : '0);
  assign tx_counted = tx_event_i.done && tx_event_i.good;
  assign tx_amount  = tx_event_i.octets + (tx_event_i.vlan_inserted ?
                      OCTET_W'(moc_pkg::VLAN_TAG_OCTETS) : '0);
  assign one_col_counted = tx_event_i.done && tx_event_i.good && (tx_event_i.collisions == 4'h1);

  assign inc_valid     = {one_col_counted, tx_counted, rx_counted};
  assign inc_amount[0] = rx_amount;
  assign inc_amount[1] = tx_amount;
  assign inc_amount[2] = OCTET_W'(1);

  ////////////////////////////////////////////////////////////////////////////////
  // Counters

  for (genvar i = 0; i < moc_pkg::NUM_CNT; i++) begin : g_cnt
    assign count_en[i] = global_counting_enable_i && !per_counter_mask_i[i];
    // A write in the same cycle as a count wins; the event is dropped
    assign load[i]     = reg_req_i.wr && (wr_index == 2'(i));
    moc_stat_counter #(
      .WIDTH  (CNT_W),
      .AMT_W  (OCTET_W),
      .THRESH (moc_pkg::CNT_THRESHOLD),
      .RESET  (moc_pkg::CNT_RESET_VALUE)
    ) u_cnt (
      .ref_clk_i    (ref_clk_i),
      .rst_i        (rst_i),
      .count_en_i   (count_en[i]),
      .inc_valid_i  (inc_valid[i]),
      .inc_amount_i (inc_amount[i]),
      .load_i       (load[i]),
      .load_value_i (reg_req_i.wdata),
      .value_o      (cnt_value[i]),
      .thresh_hit_o (thresh_hit[i])
    );
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Status flag

  // Set wins over clear so a crossing is never lost
  always_ff @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      stats_threshold_flag_o <= 1'b0;
    end else if (|thresh_hit) begin
      stats_threshold_flag_o <= 1'b1;
    end else if (stats_threshold_clear_i) begin
      stats_threshold_flag_o <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Register read port

  always_ff @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      reg_rvalid_o <= 1'b0;
    end else begin
      reg_rvalid_o <= reg_req_i.rd;
    end
  end

  always_ff @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      reg_rdata_o <= moc_pkg::UNMAPPED_VALUE;
    end else if (reg_req_i.rd) begin
      if (rd_index == moc_pkg::IDX_NONE) begin
        reg_rdata_o <= moc_pkg::UNMAPPED_VALUE;
      end else begin
        reg_rdata_o <= cnt_value[rd_index];
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Configuration read port

  always_ff @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      cfg_rvalid_o <= 1'b0;
    end else begin
      cfg_rvalid_o <= cfg_req_i.rd;
    end
  end

  always_ff @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      cfg_rdata_o <= moc_pkg::CFG_UNMAPPED;
    end else if (cfg_req_i.rd) begin
      cfg_rdata_o <= (cfg_req_i.addr == moc_pkg::CAP_ID_OFFSET) ?
                     moc_pkg::CAP_ID_POWER_MGT : moc_pkg::CFG_UNMAPPED;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Assertions

  logic [CNT_W-1:0] rx_step32;
  logic [CNT_W-1:0] tx_step32;

  assign rx_step32 = CNT_W'(rx_amount);
  assign tx_step32 = CNT_W'(tx_amount);

  property p_rx_count;
    @(posedge ref_clk_i) disable iff (rst_i)
    (rx_counted && count_en[0] && !load[0]) |=> (cnt_value[0] == $past(cnt_value[0]) + $past(rx_step32));
  endproperty
  a_rx_count: assert property (p_rx_count) else $error("Receive octet counter missed a good frame");

  property p_rx_err;
    @(posedge ref_clk_i) disable iff (rst_i)
    (rx_event_i.done && (rx_event_i.fcs_err || rx_event_i.too_long || rx_event_i.overrun
     || rx_event_i.len_err || rx_event_i.align_err) && !load[0]) |=> $stable(cnt_value[0]);
  endproperty
  a_rx_err: assert property (p_rx_err) else $error("Errored receive frame was counted");

  property p_wrap;
    @(posedge ref_clk_i) disable iff (rst_i)
    (cnt_value[2] == '1 && one_col_counted && count_en[2] && !load[2]) |=> (cnt_value[2] == '0);
  endproperty
  a_wrap: assert property (p_wrap) else $error("Counter did not roll over to zero");

  property p_vlan;
    @(posedge ref_clk_i) disable iff (rst_i)
    (rx_counted && rx_event_i.vlan_stripped && count_en[0] && !load[0])
    |=> (cnt_value[0] - $past(cnt_value[0]) == CNT_W'($past(rx_event_i.octets)) + 32'h0000_0004);
  endproperty
  a_vlan: assert property (p_vlan) else $error("Stripped tag octets not counted");

  property p_flag;
    @(posedge ref_clk_i) disable iff (rst_i)
    ($past(cnt_value[1]) < moc_pkg::CNT_THRESHOLD && cnt_value[1] >= moc_pkg::CNT_THRESHOLD
     && !$past(load[1])) |-> stats_threshold_flag_o;
  endproperty
  a_flag: assert property (p_flag) else $error("Threshold crossing did not raise the flag");

  property p_gate;
    @(posedge ref_clk_i) disable iff (rst_i)
    (!global_counting_enable_i && !reg_req_i.wr) |=> ($stable(cnt_value[0]) && $stable(cnt_value[1])
                                                     && $stable(cnt_value[2]));
  endproperty
  a_gate: assert property (p_gate) else $error("Counter moved while disabled");

  property p_tx_count;
    @(posedge ref_clk_i) disable iff (rst_i)
    (tx_counted && count_en[1] && !load[1]) |=> (cnt_value[1] == $past(cnt_value[1]) + $past(tx_step32));
  endproperty
  a_tx_count: assert property (p_tx_count) else $error("Transmit octet counter missed a frame");

  property p_col;
    @(posedge ref_clk_i) disable iff (rst_i)
    (tx_event_i.done && tx_event_i.collisions != 4'h1 && !load[2]) |=> $stable(cnt_value[2]);
  endproperty
  a_col: assert property (p_col) else $error("Single-collision counter took a wrong frame");

  property p_cap;
    @(posedge ref_clk_i) disable iff (rst_i)
    (cfg_req_i.rd && cfg_req_i.addr == moc_pkg::CAP_ID_OFFSET) |=> (cfg_rvalid_o && cfg_rdata_o == 8'h01);
  endproperty
  a_cap: assert property (p_cap) else $error("Capability ID byte is wrong");

  property p_window;
    @(posedge ref_clk_i) disable iff (rst_i)
    (reg_req_i.rd && reg_req_i.offset == moc_pkg::RX_OCTET_OFFSET)
    |=> (reg_rvalid_o && reg_rdata_o == $past(cnt_value[0]));
  endproperty
  a_window: assert property (p_window) else $error("Counter read returned wrong data");

  property p_load;
    @(posedge ref_clk_i) disable iff (rst_i)
    load[1] |=> (cnt_value[1] == $past(reg_req_i.wdata));
  endproperty
  a_load: assert property (p_load) else $error("Software write did not load the counter");

  property p_hold;
    @(posedge ref_clk_i) disable iff (rst_i)
    (per_counter_mask_i[0] && !load[0]) [*2] |=> $stable(cnt_value[0]);
  endproperty
  a_hold: assert property (p_hold) else $error("Masked counter did not hold");

  // Octet steps rarely land on all-ones, so any carry out must bring the value below its old one
  property p_wrap_rx;
    @(posedge ref_clk_i) disable iff (rst_i)
    (rx_counted && count_en[0] && !load[0] && cnt_value[0] > ~rx_step32)
    |=> (cnt_value[0] < $past(cnt_value[0]));
  endproperty
  a_wrap_rx: assert property (p_wrap_rx) else $error("Receive octet counter did not roll over");

  property p_tx_vlan;
    @(posedge ref_clk_i) disable iff (rst_i)
    (tx_counted && tx_event_i.vlan_inserted && count_en[1] && !load[1])
    |=> (cnt_value[1] - $past(cnt_value[1])
         == CNT_W'($past(tx_event_i.octets)) + CNT_W'(moc_pkg::VLAN_TAG_OCTETS));
  endproperty
  a_tx_vlan: assert property (p_tx_vlan) else $error("Inserted tag octets not counted");

  property p_flag_rx;
    @(posedge ref_clk_i) disable iff (rst_i)
    ($past(cnt_value[0]) < moc_pkg::CNT_THRESHOLD && cnt_value[0] >= moc_pkg::CNT_THRESHOLD
     && !$past(load[0])) |-> stats_threshold_flag_o;
  endproperty
  a_flag_rx: assert property (p_flag_rx) else $error("Receive crossing did not raise the flag");

  property p_flag_col;
    @(posedge ref_clk_i) disable iff (rst_i)
    ($past(cnt_value[2]) < moc_pkg::CNT_THRESHOLD && cnt_value[2] >= moc_pkg::CNT_THRESHOLD
     && !$past(load[2])) |-> stats_threshold_flag_o;
  endproperty
  a_flag_col: assert property (p_flag_col) else $error("Collision crossing did not raise the flag");

  property p_clear;
    @(posedge ref_clk_i) disable iff (rst_i)
    (stats_threshold_clear_i && !(|thresh_hit)) |=> !stats_threshold_flag_o;
  endproperty
  a_clear: assert property (p_clear) else $error("Flag did not clear");

  property p_load_rx;
    @(posedge ref_clk_i) disable iff (rst_i)
    load[0] |=> (cnt_value[0] == $past(reg_req_i.wdata));
  endproperty
  a_load_rx: assert property (p_load_rx) else $error("Write did not load the receive counter");

  property p_load_col;
    @(posedge ref_clk_i) disable iff (rst_i)
    load[2] |=> (cnt_value[2] == $past(reg_req_i.wdata));
  endproperty
  a_load_col: assert property (p_load_col) else $error("Write did not load the collision counter");

  property p_cov_flag;
    @(posedge ref_clk_i) disable iff (rst_i)
    $rose(stats_threshold_flag_o);
  endproperty
  c_cov_flag: cover property (p_cov_flag);

  property p_cov_mem_read;
    @(posedge ref_clk_i) disable iff (rst_i)
    reg_req_i.rd && reg_req_i.mem_window ##1 reg_req_i.rd && !reg_req_i.mem_window;
  endproperty
  c_cov_mem_read: cover property (p_cov_mem_read);

  property p_cov_wrap;
    @(posedge ref_clk_i) disable iff (rst_i)
    cnt_value[2] == '1 ##1 cnt_value[2] == '0;
  endproperty
  c_cov_wrap: cover property (p_cov_wrap);

  property p_cov_masked;
    @(posedge ref_clk_i) disable iff (rst_i)
    rx_counted && global_counting_enable_i && per_counter_mask_i[0];
  endproperty
  c_cov_masked: cover property (p_cov_masked);

endmodule // moc_stats_top

/* sim/moc_stats_top_test.sv */
// Testbench: octet and single-collision statistics block driven through its own ports
module moc_stats_top_test;
  timeunit 1ns;
  timeprecision 100ps;

  logic                      ref_clk_i = 1'b0;
  logic                      rst_i     = 1'b1;
  moc_pkg::moc_rx_event_type rx_ev     = '0;
  moc_pkg::moc_tx_event_type tx_ev     = '0;
  logic                      glb_en    = 1'b0;
  logic [2:0]                mask      = 3'h0;
  logic                      flag_clr  = 1'b0;
  moc_pkg::moc_reg_req_type  reg_req   = '0;
  moc_pkg::moc_cfg_req_type  cfg_req   = '0;
  logic [31:0]               reg_rdata;
  logic                      reg_rvalid;
  logic [7:0]                cfg_rdata;
  logic                      cfg_rvalid;
  logic                      flag;
  int                        errors      = 0;
  int                        comparisons = 0;
  logic [31:0]               e_rx, e_tx, e_col;

  always #4 ref_clk_i = ~ref_clk_i;

  moc_stats_top moc_stats_top_i (
    .ref_clk_i               (ref_clk_i),
    .rst_i                   (rst_i),
    .rx_event_i              (rx_ev),
    .tx_event_i              (tx_ev),
    .global_counting_enable_i(glb_en),
    .per_counter_mask_i      (mask),
    .stats_threshold_clear_i (flag_clr),
    .reg_req_i               (reg_req),
    .cfg_req_i               (cfg_req),
    .reg_rdata_o             (reg_rdata),
    .reg_rvalid_o            (reg_rvalid),
    .cfg_rdata_o             (cfg_rdata),
    .cfg_rvalid_o            (cfg_rvalid),
    .stats_threshold_flag_o  (flag)
  );

  ////////////////////////////////////////////////////////////////////////////
  task automatic wrap_up;
    if (errors == 0 && comparisons > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      errors++;
      $display("MISMATCH t=%0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  // Every strobe except the flag clear before the receive crossing is followed by an idle cycle so no signal is set twice in one step
  task automatic idle;
    @(posedge ref_clk_i);
    #1;
  endtask

  task automatic rd_chk(input logic [7:0] off, input logic mw, input logic [31:0] exp);
    reg_req.rd         = 1'b1;
    reg_req.mem_window = mw;
    reg_req.offset     = off;
    idle();
    reg_req.rd = 1'b0;
    check({31'h0, reg_rvalid}, 32'h1);
    check(reg_rdata, exp);
    idle();
    check({31'h0, reg_rvalid}, 32'h0);
  endtask

  task automatic wr(input logic [7:0] off, input logic mw, input logic [31:0] data);
    reg_req.wr         = 1'b1;
    reg_req.mem_window = mw;
    reg_req.offset     = off;
    reg_req.wdata      = data;
    idle();
    reg_req.wr = 1'b0;
    idle();
  endtask

  task automatic cfg_chk(input logic [7:0] addr, input logic [7:0] exp);
    cfg_req.rd   = 1'b1;
    cfg_req.addr = addr;
    idle();
    cfg_req.rd = 1'b0;
    check({31'h0, cfg_rvalid}, 32'h1);
    check({24'h0, cfg_rdata}, {24'h0, exp});
    idle();
    check({31'h0, cfg_rvalid}, 32'h0);
  endtask

  // Error bits in order: too_long, fcs, length, alignment, overrun
  task automatic rx_do(input logic [15:0] oct, input logic good, input logic [4:0] err, input logic strip);
    moc_pkg::moc_rx_event_type ev;
    // Built aside so the port changes once per step
    ev               = '0;
    ev.done          = 1'b1;
    ev.good          = good;
    ev.too_long      = err[0];
    ev.fcs_err       = err[1];
    ev.len_err       = err[2];
    ev.align_err     = err[3];
    ev.overrun       = err[4];
    ev.vlan_stripped = strip;
    ev.octets        = oct;
    rx_ev            = ev;
    idle();
    rx_ev.done = 1'b0;
    idle();
  endtask

  task automatic tx_do(input logic [15:0] oct, input logic good, input logic ins, input logic [3:0] col);
    moc_pkg::moc_tx_event_type ev;
    ev               = '0;
    ev.done          = 1'b1;
    ev.good          = good;
    ev.vlan_inserted = ins;
    ev.collisions    = col;
    ev.octets        = oct;
    tx_ev            = ev;
    idle();
    tx_ev.done = 1'b0;
    idle();
  endtask

  task automatic rd_all;
    rd_chk(moc_pkg::RX_OCTET_OFFSET, 1'b0, e_rx);
    rd_chk(moc_pkg::TX_OCTET_OFFSET, 1'b1, e_tx);
    rd_chk(moc_pkg::ONE_COL_OFFSET, 1'b0, e_col);
  endtask

  ////////////////////////////////////////////////////////////////////////////
  // Watchdog: a hang counts as a mismatch
  initial begin
    repeat (20000) @(posedge ref_clk_i);
    errors++;
    wrap_up();
  end

  initial begin
    e_rx  = 32'h0;
    e_tx  = 32'h0;
    e_col = 32'h0;
    repeat (5) @(posedge ref_clk_i);
    #1;
    rst_i = 1'b0;
    rd_all();
    check({31'h0, flag}, 32'h0);
    cfg_chk(moc_pkg::CAP_ID_OFFSET, 8'h01);
    cfg_chk(8'h51, 8'h00);
    // Counting disabled globally: counters hold
    rx_do(16'd60, 1'b1, 5'h0, 1'b0);
    tx_do(16'd60, 1'b1, 1'b0, 4'h1);
    rd_all();
    glb_en = 1'b1;
    rx_do(16'd60, 1'b1, 5'h0, 1'b1);
    e_rx = e_rx + 32'd64;
    rx_do(16'd46, 1'b1, 5'h0, 1'b0);
    e_rx = e_rx + 32'd46;
    rd_chk(moc_pkg::RX_OCTET_OFFSET, 1'b1, e_rx);
    for (int i = 0; i < 5; i++) begin
      rx_do(16'd100, 1'b1, 5'h1 << i, 1'b0);
    end
    rx_do(16'd100, 1'b0, 5'h0, 1'b0);
    rd_chk(moc_pkg::RX_OCTET_OFFSET, 1'b0, e_rx);
    tx_do(16'd100, 1'b1, 1'b1, 4'h0);
    e_tx = e_tx + 32'd104;
    tx_do(16'd80, 1'b1, 1'b0, 4'h1);
    e_tx = e_tx + 32'd80;
    e_col = e_col + 32'd1;
    tx_do(16'd80, 1'b1, 1'b0, 4'h2);
    e_tx = e_tx + 32'd80;
    tx_do(16'd80, 1'b0, 1'b0, 4'h1);
    rd_chk(moc_pkg::TX_OCTET_OFFSET, 1'b0, e_tx);
    rd_chk(moc_pkg::ONE_COL_OFFSET, 1'b1, e_col);
    // Each mask bit freezes only its own counter
    for (int m = 0; m < 3; m++) begin
      mask = 3'h1 << m;
      rx_do(16'd10, 1'b1, 5'h0, 1'b0);
      tx_do(16'd20, 1'b1, 1'b0, 4'h1);
      if (m != 0) e_rx = e_rx + 32'd10;
      if (m != 1) e_tx = e_tx + 32'd20;
      if (m != 2) e_col = e_col + 32'd1;
      rd_all();
    end
    mask = 3'h0;
    // Receive counter written through one window, read through the other; collision counter written and read through the I/O window
    wr(moc_pkg::RX_OCTET_OFFSET, 1'b1, 32'hffff_ffc0);
    rd_chk(moc_pkg::RX_OCTET_OFFSET, 1'b0, 32'hffff_ffc0);
    rx_do(16'd60, 1'b1, 5'h0, 1'b1);
    rd_chk(moc_pkg::RX_OCTET_OFFSET, 1'b1, 32'h0);
    e_rx = 32'h0;
    wr(moc_pkg::ONE_COL_OFFSET, 1'b0, 32'hffff_ffff);
    tx_do(16'd0, 1'b1, 1'b0, 4'h1);
    e_tx = e_tx;
    rd_chk(moc_pkg::ONE_COL_OFFSET, 1'b0, 32'h0);
    e_col = 32'h0;
    check({31'h0, flag}, 32'h0);
    // Unmapped offset: reads zero, write lost
    wr(8'hac, 1'b0, 32'h1234_5678);
    rd_chk(8'hac, 1'b0, 32'h0);
    rd_all();
    // Threshold reached exactly from below
    wr(moc_pkg::TX_OCTET_OFFSET, 1'b0, 32'hbfff_fff0);
    check({31'h0, flag}, 32'h0);
    tx_do(16'd12, 1'b1, 1'b1, 4'h0);
    check({31'h0, flag}, 32'h1);
    rd_chk(moc_pkg::TX_OCTET_OFFSET, 1'b1, moc_pkg::CNT_THRESHOLD);
    flag_clr = 1'b1;
    idle();
    flag_clr = 1'b0;
    idle();
    check({31'h0, flag}, 32'h0);
    wr(moc_pkg::ONE_COL_OFFSET, 1'b1, 32'hbfff_ffff);
    wr(moc_pkg::TX_OCTET_OFFSET, 1'b1, 32'h0);
    tx_do(16'd0, 1'b1, 1'b0, 4'h1);
    check({31'h0, flag}, 32'h1);
    // Receive counter crossing raises the flag as well
    flag_clr = 1'b1;
    idle();
    flag_clr = 1'b0;
    wr(moc_pkg::RX_OCTET_OFFSET, 1'b0, 32'hbfff_ffc0);
    check({31'h0, flag}, 32'h0);
    rx_do(16'd60, 1'b1, 5'h0, 1'b1);
    check({31'h0, flag}, 32'h1);
    rd_chk(moc_pkg::RX_OCTET_OFFSET, 1'b1, moc_pkg::CNT_THRESHOLD);
    wrap_up();
  end
endmodule // moc_stats_top_test
